// file: hw/spsc_map.svh
// Purpose: Offsets, field positions and reset values of the PCS status and counter bank
// Assumes: 16-bit management registers, word addressed
// Notes: Definitions only
`ifndef SPSC_MAP_SVH
`define SPSC_MAP_SVH
`define SPSC_ADDR_W 5
`define SPSC_OFF_MAC_ADV 5'h12
`define SPSC_OFF_MAC_LP 5'h13
`define SPSC_OFF_MAC_STAT 5'h14
`define SPSC_OFF_TX_GOOD 5'h15
`define SPSC_OFF_TX_CRC 5'h16
`define SPSC_OFF_MEDIA_CTL 5'h17
`define SPSC_OFF_MEDIA_ADV 5'h19
`define SPSC_GOOD_WRAP 14'h270F
`define SPSC_CRC_MAX 8'hFF
`define SPSC_RST_MAC_ADV 16'h0000
`define SPSC_RST_MEDIA_ADV 16'h0000
`define SPSC_RST_SEL 2'h0
`define SPSC_SEL_MEDIA 2'h0
`define SPSC_SEL_MAC 2'h1
`define SPSC_BIT_REALIGN 15
`define SPSC_BIT_SIGDET 14
`define SPSC_BIT_QSYNC 13
`define SPSC_BIT_COMMA 12
`define SPSC_BIT_ACTIVE 15
`define SPSC_BIT_PREFIX 13
`define SPSC_BIT_PARDET 13
`define SPSC_BIT_CEXTDIS 12
`define SPSC_BIT_FORCEADV 11
`define SPSC_BIT_POLIN 6
`define SPSC_BIT_POLOUT 5
`define SPSC_BIT_ODDINH 4
`define SPSC_BIT_HLS 2
`define SPSC_BIT_FEFIF 1
`define SPSC_BIT_FEFIV 0
`endif

// file: hw/spsc_pkg.sv
// Purpose: Types of the PCS status and counter bank
// Assumes: Constants live in spsc_map.svh
// Notes: One state struct per module
package spsc_pkg;
   typedef struct packed {
      logic pdFefiOn;
      logic fefiForce;
      logic fefiValue;
      logic forceHls;
      logic oddInhibit;
      logic polOut;
      logic polIn;
      logic mediaForceAdv;
      logic carrierExtDis;
      logic parallelDetect;
      logic preambleFix;
      logic [1:0] txSelect;
   } spsc_ctrl_type;
   typedef struct packed {
      logic [15:0] macAdv;
      logic [15:0] mediaAdv;
      logic [15:0] macLp;
      logic realign;
      logic sigDet;
      logic commaDet;
      logic goodActive;
      logic [13:0] goodCount;
      logic [7:0] crcCount;
      logic [15:0] rdData;
      spsc_ctrl_type ctrl;
      logic [15:0] advOut;
   } spsc_state_type;
endpackage : spsc_pkg

// file: hw/spsc_bank.sv
// Purpose: Per-port MAC and media SerDes PCS status, counters and media PCS control
// Assumes: Event inputs are one-cycle pulses on clk; levels are synchronous to clk
// Notes: Read data stands in the cycle after the read strobe
//
// Operation
// - MAC advertised word, reset zero, writable only while force-advertise bit set.
// - MAC advertised word read undefined in protocol transfer without forcing.
// - Partner code word read-only, updated on each received word.
// - MAC status bit 15 latches on comma realignment, sticky, cleared by read.
// - MAC status bit 14 latches on signal detection, sticky, cleared by read.
// - MAC status bit 13 shows QSGMII sync, meaningful on first port only.
// - Comma detect reads one with commas, clears without, read sets it again.
// - Four-bit comma position 0 to 9, meaningless under QSGMII.
// - Good packet register bit 15 shows counter active.
// - Good packet count fourteen bits, wraps to zero after 9999.
// - Two-bit counter select, 00 media, 01 MAC, reset zero.
// - Transmit counters count only while media link is up.
// - Preamble fix drops one byte of preambles over eight bytes.
// - CRC error count eight bits, saturating at 255.
// - Remote fault field reflects code sent in latest negotiation.
// - Parallel detection enable bit, reset zero.
// - Carrier extension disable bit, reset one.
// - Media force bit advertises media advertised word instead of generated.
// - Input and output polarity inversion bits, reset zero.
// - Odd-start inhibit, reset one: drop first 0x55 byte, else delay.
// - Force HLS bit transmits Halt Line State continuously.
// - Force FEFI bit drives fault indication from value bit.
// - Force value one turns FEFI on, zero suppresses; resets zero.
//
// Strobed register access was left to the implementer.
`include "spsc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module spsc_bank
   import spsc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [4:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   output logic [15:0] regRdData,
   input wire logic firstPort,
   input wire logic qsgmiiMode,
   input wire logic protoTransfer,
   input wire logic macForceAdvertBit,
   input wire logic [15:0] macAutoAdv,
   input wire logic [15:0] mediaAutoAdv,
   input wire logic [15:0] macRxWord,
   input wire logic macRxWordValid,
   input wire logic [15:0] mediaRxWord,
   input wire logic mediaRxWordValid,
   input wire logic macRealignPulse,
   input wire logic macSigDetPulse,
   input wire logic macCommaSeen,
   input wire logic qsgmiiSync,
   input wire logic [3:0] macCommaPos,
   input wire logic mediaLinkUp,
   input wire logic mediaTxGoodPulse,
   input wire logic mediaTxCrcPulse,
   input wire logic macTxGoodPulse,
   input wire logic macTxCrcPulse,
   input wire logic [1:0] remoteFaultSent,
   input wire logic autoFefi,
   output logic [15:0] mediaAdvWord,
   output logic parallelDetectEn,
   output logic carrierExtDisable,
   output logic mediaPolarityIn,
   output logic mediaPolarityOut,
   output logic oddStartInhibit,
   output logic txPreambleFix,
   output logic fxForceHls,
   output logic fxFefiOn,
   output logic [1:0] txCounterSelect
);
   spsc_state_type s_q;
   spsc_state_type s_d;
   logic [15:0] lpSel;
   logic goodEv;
   logic crcEv;
   logic [15:0] rd;
   always_comb begin
      s_d = s_q;
      // Media partner word registers elsewhere; MAC side kept here
      if (macRxWordValid) begin
         s_d.macLp = macRxWord;
      end
      lpSel = s_q.macLp;
      // Selected source feeds the shared counters
      if (s_q.ctrl.txSelect == `SPSC_SEL_MAC) begin
         goodEv = macTxGoodPulse;
         crcEv = macTxCrcPulse;
      end else if (s_q.ctrl.txSelect == `SPSC_SEL_MEDIA) begin
         goodEv = mediaTxGoodPulse;
         crcEv = mediaTxCrcPulse;
      end else begin
         // Reserved codes count nothing
         goodEv = 1'b0;
         crcEv = 1'b0;
      end
      s_d.goodActive = mediaLinkUp;
      if (mediaLinkUp && goodEv) begin
         s_d.goodCount = (s_q.goodCount == `SPSC_GOOD_WRAP) ? 14'h0000 : s_q.goodCount + 14'h0001;
      end
      if (mediaLinkUp && crcEv && s_q.crcCount != `SPSC_CRC_MAX) begin
         s_d.crcCount = s_q.crcCount + 8'h01;
      end
      // Read mux
      rd = 16'h0000;
      case (regAddr)
         `SPSC_OFF_MAC_ADV: begin
            // Undefined in protocol transfer without forcing; zero is one legal answer
            rd = (protoTransfer && !macForceAdvertBit) ? 16'h0000 : s_q.macAdv;
         end
         `SPSC_OFF_MAC_LP: begin
            rd = lpSel;
         end
         `SPSC_OFF_MAC_STAT: begin
            rd[`SPSC_BIT_REALIGN] = s_q.realign;
            rd[`SPSC_BIT_SIGDET] = s_q.sigDet;
            rd[`SPSC_BIT_QSYNC] = firstPort & qsgmiiSync;
            rd[`SPSC_BIT_COMMA] = s_q.commaDet;
            rd[11:8] = qsgmiiMode ? 4'h0 : macCommaPos;
         end
         `SPSC_OFF_TX_GOOD: begin
            rd[`SPSC_BIT_ACTIVE] = s_q.goodActive;
            rd[13:0] = s_q.goodCount;
         end
         `SPSC_OFF_TX_CRC: begin
            rd[15:14] = s_q.ctrl.txSelect;
            rd[`SPSC_BIT_PREFIX] = s_q.ctrl.preambleFix;
            rd[7:0] = s_q.crcCount;
         end
         `SPSC_OFF_MEDIA_CTL: begin
            rd[15:14] = remoteFaultSent;
            rd[`SPSC_BIT_PARDET] = s_q.ctrl.parallelDetect;
            rd[`SPSC_BIT_CEXTDIS] = s_q.ctrl.carrierExtDis;
            rd[`SPSC_BIT_FORCEADV] = s_q.ctrl.mediaForceAdv;
            rd[`SPSC_BIT_POLIN] = s_q.ctrl.polIn;
            rd[`SPSC_BIT_POLOUT] = s_q.ctrl.polOut;
            rd[`SPSC_BIT_ODDINH] = s_q.ctrl.oddInhibit;
            rd[`SPSC_BIT_HLS] = s_q.ctrl.forceHls;
            rd[`SPSC_BIT_FEFIF] = s_q.ctrl.fefiForce;
            rd[`SPSC_BIT_FEFIV] = s_q.ctrl.fefiValue;
         end
         `SPSC_OFF_MEDIA_ADV: begin
            rd = s_q.mediaAdv;
         end
         default: begin
            rd = 16'h0000;
         end
      endcase
      if (regRdStb) begin
         s_d.rdData = rd;
      end
      // Comma bit follows commas; a read restores one, absence clears it next cycle
      s_d.commaDet = macCommaSeen;
      // Sticky bits: read clears, a same-cycle event wins
      if (regRdStb && regAddr == `SPSC_OFF_MAC_STAT) begin
         s_d.realign = 1'b0;
         s_d.sigDet = 1'b0;
         s_d.commaDet = 1'b1;
      end
      if (macRealignPulse) begin
         s_d.realign = 1'b1;
      end
      if (macSigDetPulse) begin
         s_d.sigDet = 1'b1;
      end
      // Writes
      if (regWrStb) begin
         case (regAddr)
            `SPSC_OFF_MAC_ADV: begin
               if (macForceAdvertBit) begin
                  s_d.macAdv = regWrData;
               end
            end
            `SPSC_OFF_TX_CRC: begin
               s_d.ctrl.txSelect = regWrData[15:14];
               s_d.ctrl.preambleFix = regWrData[`SPSC_BIT_PREFIX];
            end
            `SPSC_OFF_MEDIA_CTL: begin
               s_d.ctrl.parallelDetect = regWrData[`SPSC_BIT_PARDET];
               s_d.ctrl.carrierExtDis = regWrData[`SPSC_BIT_CEXTDIS];
               s_d.ctrl.mediaForceAdv = regWrData[`SPSC_BIT_FORCEADV];
               s_d.ctrl.polIn = regWrData[`SPSC_BIT_POLIN];
               s_d.ctrl.polOut = regWrData[`SPSC_BIT_POLOUT];
               s_d.ctrl.oddInhibit = regWrData[`SPSC_BIT_ODDINH];
               s_d.ctrl.forceHls = regWrData[`SPSC_BIT_HLS];
               s_d.ctrl.fefiForce = regWrData[`SPSC_BIT_FEFIF];
               s_d.ctrl.fefiValue = regWrData[`SPSC_BIT_FEFIV];
            end
            `SPSC_OFF_MEDIA_ADV: begin
               // Writable only while media forcing is on, mirrors MAC side
               if (s_q.ctrl.mediaForceAdv) begin
                  s_d.mediaAdv = regWrData;
               end
            end
            default: begin
            end
         endcase
      end
      // Advertised word to media: forced or generated
      s_d.advOut = s_q.ctrl.mediaForceAdv ? s_q.mediaAdv : mediaAutoAdv;
      s_d.ctrl.pdFefiOn = s_q.ctrl.fefiForce ? s_q.ctrl.fefiValue : autoFefi;
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '0;
         s_q.macAdv <= `SPSC_RST_MAC_ADV;
         s_q.mediaAdv <= `SPSC_RST_MEDIA_ADV;
         s_q.commaDet <= 1'b0;
         s_q.ctrl.txSelect <= `SPSC_RST_SEL;
         s_q.ctrl.carrierExtDis <= 1'b1;
         s_q.ctrl.oddInhibit <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end
   assign regRdData = s_q.rdData;
   assign mediaAdvWord = s_q.advOut;
   assign parallelDetectEn = s_q.ctrl.parallelDetect;
   assign carrierExtDisable = s_q.ctrl.carrierExtDis;
   assign mediaPolarityIn = s_q.ctrl.polIn;
   assign mediaPolarityOut = s_q.ctrl.polOut;
   assign oddStartInhibit = s_q.ctrl.oddInhibit;
   assign txPreambleFix = s_q.ctrl.preambleFix;
   assign fxForceHls = s_q.ctrl.forceHls;
   assign fxFefiOn = s_q.ctrl.pdFefiOn;
   assign txCounterSelect = s_q.ctrl.txSelect;
endmodule : spsc_bank
`default_nettype wire

// file: tb/spsc_bank_chk.sv
// Purpose: Port properties of spsc_bank
// Assumes: One clock, rst_b active low
// Notes: Bound into every instance
`timescale 1ns/1ps
`default_nettype none
module spsc_bank_chk (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [4:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   input wire logic [15:0] regRdData,
   input wire logic firstPort,
   input wire logic qsgmiiSync,
   input wire logic [15:0] macRxWord,
   input wire logic macRxWordValid,
   input wire logic macRealignPulse,
   input wire logic macSigDetPulse,
   input wire logic macCommaSeen,
   input wire logic parallelDetectEn,
   input wire logic carrierExtDisable,
   input wire logic mediaPolarityIn,
   input wire logic mediaPolarityOut,
   input wire logic oddStartInhibit,
   input wire logic fxForceHls,
   input wire logic fxFefiOn,
   input wire logic txPreambleFix,
   input wire logic [1:0] txCounterSelect
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire rd14 = regRdStb && regAddr == 5'h14;
   wire wr17 = regWrStb && regAddr == 5'h17;
   logic realignPend;
   logic sigDetPend;
   // Reference of the sticky bits: set by an event, cleared by a status read
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         realignPend <= 1'b0;
         sigDetPend <= 1'b0;
      end else begin
         realignPend <= macRealignPulse || (realignPend && !rd14);
         sigDetPend <= macSigDetPulse || (sigDetPend && !rd14);
      end
   end
   a_sel_write:
      assert property (regWrStb && regAddr == 5'h16 |=> {txCounterSelect, txPreambleFix} == $past(regWrData[15:13]))
      else $error("counter select write lost");
   a_ctl_write:
      assert property (wr17 |=> {parallelDetectEn, carrierExtDisable, mediaPolarityIn, mediaPolarityOut,
         oddStartInhibit, fxForceHls} == {$past(regWrData[13:12]), $past(regWrData[6:4]), $past(regWrData[2])})
      else $error("control write lost");
   a_fefi_force:
      assert property (wr17 && regWrData[1] ##1 !regWrStb |=> fxFefiOn == $past(regWrData[0], 2))
      else $error("forced fault value wrong");
   a_realign_set:
      assert property (rd14 && realignPend |=> regRdData[15]) else $error("realign not held");
   a_sigdet_set:
      assert property (rd14 && sigDetPend |=> regRdData[14]) else $error("sigdet not held");
   a_sticky_clear:
      assert property (rd14 && !macRealignPulse ##1 !regRdStb && !macRealignPulse ##1 rd14 |=> !regRdData[15])
      else $error("realign not cleared by read");
   a_comma_seen:
      assert property (rd14 && macCommaSeen && $past(macCommaSeen) |=> regRdData[12]) else $error("comma bit low");
   a_qsync_bit:
      assert property (rd14 && $stable(firstPort) && $stable(qsgmiiSync) |=>
         regRdData[13] == $past(firstPort && qsgmiiSync)) else $error("sync bit wrong");
   a_lp_word:
      assert property (macRxWordValid ##1 !macRxWordValid ##1 regRdStb && regAddr == 5'h13 |=>
         regRdData == $past(macRxWord, 3)) else $error("partner word wrong");
   c_realign: cover property (macRealignPulse ##4 rd14);
   c_fefi: cover property (wr17 && regWrData[1]);
   c_lp: cover property (macRxWordValid ##2 regRdStb);
endmodule : spsc_bank_chk
bind spsc_bank spsc_bank_chk spsc_bank_chk_i (.*);
`default_nettype wire

// file: tb/spsc_mac_model.sv
// Purpose: MAC side stimulus: code words, link events, commas
// Assumes: Drives after rising edges only
// Notes: Events: 3 realign, 2 sigdet, 1 tx good, 0 tx crc
`timescale 1ns/1ps
`default_nettype none
module spsc_mac_model (
   input wire logic clk,
   output logic [15:0] macRxWord,
   output logic macRxWordValid,
   output logic [3:0] macEvents,
   output logic macCommaSeen
);
   initial begin
      macRxWord = 16'h0000;
      macRxWordValid = 1'b0;
      macEvents = 4'h0;
      macCommaSeen = 1'b0;
   end
   task automatic sendWord(input logic [15:0] w);
      @(posedge clk);
      macRxWord <= w;
      macRxWordValid <= 1'b1;
      @(posedge clk);
      macRxWordValid <= 1'b0;
      macRxWord <= ~w; // Stale word must never pass as valid
   endtask : sendWord
   task automatic setComma(input logic v);
      @(posedge clk);
      macCommaSeen <= v;
   endtask : setComma
   task automatic burst(input int k, input int n);
      repeat (n) begin
         @(posedge clk);
         macEvents[k] <= 1'b1;
         @(posedge clk);
         macEvents[k] <= 1'b0;
      end
   endtask : burst
endmodule : spsc_mac_model
`default_nettype wire

// file: tb/tb_top.sv
// Purpose: Register level test of spsc_bank
// Assumes: Read data sampled one cycle after strobe
// Notes: Counter wrap needs 10000 packets
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk, rst_b, regWrStb, regRdStb, firstPort, qsgmiiMode, protoTransfer, macForceAdvertBit, qsgmiiSync;
   logic mediaLinkUp, mediaTxGoodPulse, mediaTxCrcPulse, autoFefi, mediaRxWordValid, macRxWordValid, macCommaSeen;
   logic parallelDetectEn, carrierExtDisable, mediaPolarityIn, mediaPolarityOut, oddStartInhibit;
   logic txPreambleFix, fxForceHls, fxFefiOn;
   logic [4:0] regAddr;
   logic [15:0] regWrData, regRdData, mediaAdvWord, macAutoAdv, mediaAutoAdv, mediaRxWord, macRxWord;
   logic [3:0] macCommaPos, macEvents;
   logic [1:0] remoteFaultSent, txCounterSelect;
   int num_errors, num_checks;
   wire [15:0] ctlOut = {8'h00, txPreambleFix, parallelDetectEn, carrierExtDisable, mediaPolarityIn,
      mediaPolarityOut, oddStartInhibit, fxForceHls, fxFefiOn};
   spsc_bank spsc_bank_i (.macRealignPulse(macEvents[3]), .macSigDetPulse(macEvents[2]),
      .macTxGoodPulse(macEvents[1]), .macTxCrcPulse(macEvents[0]), .*);
   spsc_mac_model spsc_mac_model_i (.*);
   always #10 clk = ~clk;
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      num_checks++;
      if (s !== e) begin
         num_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWrStb <= 1'b1;
      @(posedge clk);
      regWrStb <= 1'b0;
   endtask : wr
   task automatic rd(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
      @(posedge clk);
      regAddr <= a;
      regRdStb <= 1'b1;
      @(posedge clk);
      regRdStb <= 1'b0;
      #1;
      chk(regRdData & m, e);
   endtask : rd
   task automatic settle;
      repeat (2) @(posedge clk);
      #1;
   endtask : settle
   task automatic goods(input int n);
      repeat (n) begin
         @(posedge clk);
         mediaTxGoodPulse <= 1'b1;
         @(posedge clk);
         mediaTxGoodPulse <= 1'b0;
      end
   endtask : goods
   task automatic summarize;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : summarize
   initial begin
      #1000000;
      num_errors++;
      summarize();
   end
   initial begin
      {clk, rst_b, regWrStb, regRdStb, firstPort, qsgmiiMode, protoTransfer, macForceAdvertBit} = 8'h00;
      {qsgmiiSync, mediaLinkUp, mediaTxGoodPulse, mediaTxCrcPulse, autoFefi, mediaRxWordValid} = 6'h00;
      {regAddr, regWrData, macAutoAdv, mediaRxWord} = 53'h0;
      {mediaAutoAdv, macCommaPos, remoteFaultSent} = {16'h1111, 4'h9, 2'h2};
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      settle();
      chk(ctlOut, 16'h0024);
      chk(mediaAdvWord, 16'h1111);
      rd(5'h16, 16'hFFFF, 16'h0000);
      wr(5'h12, 16'hA5A5);
      rd(5'h12, 16'hFFFF, 16'h0000);
      @(posedge clk) macForceAdvertBit <= 1'b1;
      wr(5'h12, 16'hA5A5);
      rd(5'h12, 16'hFFFF, 16'hA5A5);
      @(posedge clk) protoTransfer <= 1'b1;
      rd(5'h12, 16'hFFFF, 16'hA5A5);
      @(posedge clk) protoTransfer <= 1'b0;
      spsc_mac_model_i.sendWord(16'h1234);
      rd(5'h13, 16'hFFFF, 16'h1234);
      spsc_mac_model_i.burst(3, 1);
      spsc_mac_model_i.burst(2, 1);
      rd(5'h14, 16'hC000, 16'hC000);
      rd(5'h14, 16'hC000, 16'h0000);
      @(posedge clk) {firstPort, qsgmiiSync} <= 2'h3;
      rd(5'h14, 16'h2F00, 16'h2900);
      @(posedge clk) qsgmiiMode <= 1'b1;
      rd(5'h14, 16'h0F00, 16'h0000);
      spsc_mac_model_i.setComma(1'b1);
      {firstPort, qsgmiiMode} <= 2'h0;
      rd(5'h14, 16'h3000, 16'h1000);
      spsc_mac_model_i.setComma(1'b0);
      settle();
      rd(5'h14, 16'h1000, 16'h0000);
      wr(5'h19, 16'hFFFF);
      rd(5'h19, 16'hFFFF, 16'h0000);
      wr(5'h17, 16'h2877);
      wr(5'h19, 16'h0020);
      settle();
      chk(ctlOut, 16'h005F);
      chk(mediaAdvWord, 16'h0020);
      rd(5'h17, 16'hFFFF, 16'hA877);
      @(posedge clk) autoFefi <= 1'b1;
      wr(5'h17, 16'h0002);
      settle();
      chk(ctlOut, 16'h0000);
      wr(5'h17, 16'h0000);
      settle();
      chk(ctlOut, 16'h0001);
      goods(3);
      rd(5'h15, 16'hFFFF, 16'h0000);
      @(posedge clk) mediaLinkUp <= 1'b1;
      goods(10001);
      rd(5'h15, 16'hFFFF, 16'h8001);
      wr(5'h16, 16'h6000);
      goods(1);
      spsc_mac_model_i.burst(1, 2);
      rd(5'h15, 16'hFFFF, 16'h8003);
      spsc_mac_model_i.burst(0, 260);
      rd(5'h16, 16'hFFFF, 16'h60FF);
      wr(5'h16, 16'hC000);
      spsc_mac_model_i.burst(1, 1);
      rd(5'h15, 16'hFFFF, 16'h8003);
      rd(5'h05, 16'hFFFF, 16'h0000);
      summarize();
   end
endmodule : tb_top
`default_nettype wire
